//--- common/dsr_pkg.sv
// Shared constants and carrier types for the dual-slope readout sequencer.
// Assumes a single 25 MHz system clock; the analog front end sits outside.
package dsr_pkg;

   // System clock
   localparam int CLK_HZ = 25_000_000;
   localparam int CLK_NS = 40;

   // Internal timebase rate and the conversion start rates, in hertz
   localparam int OSC_HZ = 786;
   localparam int FAST_HZ = 96;
   localparam int SLOW_HZ = 4;

   // Clock cycles per timebase tick, rounded down (above 4096: a top parameter)
   localparam int OSC_CYCLES_DFLT = CLK_HZ / OSC_HZ;

   // Timebase ticks between conversion starts
   localparam int RATE_W = 8;
   localparam logic [RATE_W-1:0] FAST_TICKS = RATE_W'(OSC_HZ / FAST_HZ);
   localparam logic [RATE_W-1:0] SLOW_TICKS = RATE_W'(OSC_HZ / SLOW_HZ);

   // Conversion: integrate and de-integrate each last about half of 5 ms
   localparam int CONV_US = 5000;
   localparam int FULL_COUNTS = 1000;
   localparam int COUNT_TICK_NS = CONV_US * 1000 / (2 * FULL_COUNTS);
   localparam int COUNT_CYCLES_DFLT = COUNT_TICK_NS / CLK_NS;
   localparam int INT_COUNTS_DFLT = FULL_COUNTS;

   // Readout codes
   localparam int DIGITS = 3;
   localparam logic [3:0] BCD_NINE = 4'h9;
   localparam logic [3:0] NEG_OVR_CODE = 4'ha;
   localparam logic [3:0] MINUS_CODE = 4'ha;
   localparam logic [3:0] POS_OVR_CODE = 4'hb;

   // Scan: gap, top, gap, middle, gap, bottom
   localparam int SCAN_W = 3;
   localparam logic [SCAN_W-1:0] SCAN_LAST = 3'h5;

   // Decoded rate/hold input
   typedef enum logic [2:0] {
      MODE_SLOW = 3'b001,
      MODE_FAST = 3'b010,
      MODE_HOLD = 3'b100
   } rate_mode_t;

   // Converter sequence states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_INTEG = 3'b010,
      ST_DEINT = 3'b100
   } conv_state_t;

   // Digit select strobes, active high
   typedef struct packed {
      logic top_digit_select;
      logic middle_digit_select;
      logic bottom_digit_select;
   } digit_sel_t;

   // One multiplexed readout beat
   typedef struct packed {
      logic [3:0] bcd;
      digit_sel_t sel;
   } readout_t;

endpackage

//--- rtl/dual_slope_bcd_readout_sequencer.sv
// Digital sequencer for a dual-slope converter with a three-digit multiplexed BCD readout.
// Assumes the integrator, reference source and comparators are outside, and that the
// three-level rate pin is sliced by two outside comparators into rate_high_pin/rate_mid_pin.

// Function
// R1: Connect input current for a fixed tick count, then switch in opposite reference.
// R2: During de-integration count ticks until the comparator reports charge restored.
// R3: Latch the count on restoration; it stays shown until a later conversion.
// R4: Show the latched result one digit at a time on four BCD outputs.
// R5: All timing comes from an internal free-running 786 Hz timebase, no clock pin; here the timebase and count tick are divided from the clk pin.
// R6: Rate pin high starts conversions at 96 Hz; low or open gives 4 Hz.
// R7: In hold keep converting at 4 Hz but freeze the shown result.
// R8: After hold the display updates again, conversions stay at 4 Hz.
// R9: One integrate plus de-integrate takes about 5 ms in either rate.
// R10: Negative overrange shows code 1010 on all digits, positive overrange 1011.
// R11: Negative results to -99 show a minus in the top digit, magnitude below.
// R12: Outside latches capture BCD data on their own inverted digit select.
// R13: At most one digit select active; BCD holds that digit while it is active.
// R14: Rate/hold pin is decoded to fast, slow or hold; hold forces slow rate.
module dual_slope_bcd_readout_sequencer #(
   parameter int OSC_CYCLES = dsr_pkg::OSC_CYCLES_DFLT,
   parameter int COUNT_CYCLES = dsr_pkg::COUNT_CYCLES_DFLT,
   parameter int INT_COUNTS = dsr_pkg::INT_COUNTS_DFLT
) (
   input wire logic clk,                      // 25 MHz system clock
   input wire logic sys_rst,                  // Asynchronous reset, active high
   input wire logic rate_high_pin,            // Rate pin sliced high: fast rate asked
   input wire logic rate_mid_pin,             // Rate pin sliced mid-level: hold asked
   input wire logic restore_pin,              // Comparator: integrator charge restored
   input wire logic sign_pin,                 // Comparator: integrated input is negative
   output logic integ_connect,                // Input current switched onto integrator
   output logic ref_connect,                  // Reference current switched onto integrator
   output dsr_pkg::readout_t readout,         // Multiplexed BCD data and digit selects
   output logic conv_done                     // One-cycle pulse at end of each conversion
);

   localparam int OSC_W = $clog2(OSC_CYCLES + 1);
   localparam int CT_W = $clog2(COUNT_CYCLES + 1);
   localparam int INT_W = $clog2(INT_COUNTS + 1);
   localparam int SYNC_N = 4;
   localparam int RATE_W_L = dsr_pkg::RATE_W;

   // Synchroniser stages for the four outside inputs
   logic [SYNC_N-1:0] sync1_q;
   logic [SYNC_N-1:0] sync2_q;
   logic rate_high_s;
   logic rate_mid_s;
   logic restore_s;
   logic sign_s;

   // Mode and rate
   dsr_pkg::rate_mode_t mode_w;
   logic slow_lock_q;
   logic fast_w;
   logic [RATE_W_L-1:0] rate_cnt_q;
   logic [RATE_W_L-1:0] period_w;
   logic start_w;

   // Timebase and count tick
   logic [OSC_W-1:0] osc_cnt_q;
   logic osc_tick;
   logic [CT_W-1:0] ct_cnt_q;
   logic ct_tick;

   // Conversion sequence
   dsr_pkg::conv_state_t state_q;
   dsr_pkg::conv_state_t state_d;
   logic [INT_W-1:0] int_cnt_q;
   logic int_last_w;
   logic neg_q;
   logic [3:0] cnt_q [dsr_pkg::DIGITS];
   logic [dsr_pkg::DIGITS:0] carry_w;
   logic end_w;
   logic ovf_w;

   // Result formatting and display
   logic [3:0] fmt_w [dsr_pkg::DIGITS];
   logic [3:0] shown_q [dsr_pkg::DIGITS];
   logic upd_w;
   logic pos_ovr_w;
   logic neg_ovr_w;
   logic hundreds_nz_w;

   // Scan
   logic [dsr_pkg::SCAN_W-1:0] scan_q;
   logic [dsr_pkg::SCAN_W-1:0] scan_next_w;
   logic [1:0] scan_dig_w;
   logic scan_on_w;
   dsr_pkg::readout_t readout_q;
   dsr_pkg::readout_t readout_d;
   logic conv_done_q;

   // Two flops on every pin before any logic looks at it
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= {sign_pin, restore_pin, rate_mid_pin, rate_high_pin};
         sync2_q <= sync1_q;
      end
   end

   assign rate_high_s = sync2_q[0];
   assign rate_mid_s = sync2_q[1];
   assign restore_s = sync2_q[2];
   assign sign_s = sync2_q[3];

   // Mid-level wins over high: while the pin slews through the hold band it
   // may briefly look like both, and hold is the safe reading then
   assign mode_w = rate_mid_s ? dsr_pkg::MODE_HOLD :                      // R14
                   rate_high_s ? dsr_pkg::MODE_FAST : dsr_pkg::MODE_SLOW; // R14

   // Once hold has been seen the rate stays slow until reset
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         slow_lock_q <= 1'b0;
      end else if (mode_w == dsr_pkg::MODE_HOLD) begin
         slow_lock_q <= 1'b1; // R8
      end
   end

   assign fast_w = (mode_w == dsr_pkg::MODE_FAST) && !slow_lock_q; // R14
   assign period_w = fast_w ? dsr_pkg::FAST_TICKS : dsr_pkg::SLOW_TICKS; // R6

   // Free-running timebase derived from the system clock
   assign osc_tick = (osc_cnt_q == OSC_W'(OSC_CYCLES - 1)); // R5

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         osc_cnt_q <= '0;
      end else if (osc_tick) begin
         osc_cnt_q <= '0; // R5
      end else begin
         osc_cnt_q <= osc_cnt_q + 1'b1;
      end
   end

   // Start timer counts timebase ticks; >= lets a rate change take effect at once
   assign start_w = osc_tick && (rate_cnt_q >= period_w - 1'b1); // R6

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rate_cnt_q <= '0;
      end else if (start_w) begin
         rate_cnt_q <= '0;
      end else if (osc_tick) begin
         rate_cnt_q <= rate_cnt_q + 1'b1;
      end
   end

   // Count tick runs only inside a conversion, so both slopes start phase-aligned
   assign ct_tick = (state_q != dsr_pkg::ST_IDLE) && (ct_cnt_q == CT_W'(COUNT_CYCLES - 1));

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ct_cnt_q <= '0;
      end else if (state_q == dsr_pkg::ST_IDLE || ct_tick) begin
         ct_cnt_q <= '0;
      end else begin
         ct_cnt_q <= ct_cnt_q + 1'b1; // R9
      end
   end

   // Integration length in count ticks
   assign int_last_w = ct_tick && (int_cnt_q == INT_W'(INT_COUNTS - 1)); // R1

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         int_cnt_q <= '0;
      end else if (state_q != dsr_pkg::ST_INTEG) begin
         int_cnt_q <= '0;
      end else if (ct_tick) begin
         int_cnt_q <= int_cnt_q + 1'b1; // R1
      end
   end

   // De-integration ends on restoration, or on running past full scale
   assign end_w = (state_q == dsr_pkg::ST_DEINT) && (restore_s || carry_w[dsr_pkg::DIGITS]);
   assign ovf_w = !restore_s && carry_w[dsr_pkg::DIGITS];

   // Sequence: idle, integrate input, de-integrate against reference
   always_comb begin
      state_d = state_q;
      case (state_q)
         dsr_pkg::ST_IDLE: begin
            if (start_w) begin
               state_d = dsr_pkg::ST_INTEG; // R1
            end
         end
         dsr_pkg::ST_INTEG: begin
            if (int_last_w) begin
               state_d = dsr_pkg::ST_DEINT; // R1
            end
         end
         dsr_pkg::ST_DEINT: begin
            if (end_w) begin
               state_d = dsr_pkg::ST_IDLE; // R2
            end
         end
         default: begin
            state_d = dsr_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= dsr_pkg::ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Input polarity is taken as integration ends, before the reference swings it back
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         neg_q <= 1'b0;
      end else if (int_last_w) begin
         neg_q <= sign_s;
      end
   end

   // Decade counter for the de-integration count, one digit per loop pass
   assign carry_w[0] = ct_tick && (state_q == dsr_pkg::ST_DEINT) && !restore_s; // R2

   for (genvar i = 0; i < dsr_pkg::DIGITS; i++) begin : g_dec
      logic at_nine_w;

      assign at_nine_w = (cnt_q[i] == dsr_pkg::BCD_NINE);
      assign carry_w[i+1] = carry_w[i] && at_nine_w;

      always_ff @(posedge clk or posedge sys_rst) begin
         if (sys_rst) begin
            cnt_q[i] <= '0;
         end else if (int_last_w) begin
            cnt_q[i] <= '0; // R2
         end else if (carry_w[i]) begin
            cnt_q[i] <= at_nine_w ? '0 : cnt_q[i] + 1'b1; // R2
         end
      end
   end

   // Result formatting; index 2 is the top digit
   assign hundreds_nz_w = (cnt_q[2] != '0);
   assign pos_ovr_w = ovf_w && !neg_q;
   assign neg_ovr_w = neg_q && (ovf_w || hundreds_nz_w);

   always_comb begin
      for (int k = 0; k < dsr_pkg::DIGITS; k++) begin
         fmt_w[k] = cnt_q[k];
      end
      if (pos_ovr_w) begin
         for (int k = 0; k < dsr_pkg::DIGITS; k++) begin
            fmt_w[k] = dsr_pkg::POS_OVR_CODE; // R10
         end
      end else if (neg_ovr_w) begin
         for (int k = 0; k < dsr_pkg::DIGITS; k++) begin
            fmt_w[k] = dsr_pkg::NEG_OVR_CODE; // R10
         end
      end else if (neg_q) begin
         fmt_w[2] = dsr_pkg::MINUS_CODE; // R11
      end
   end

   // Shown result is latched at the end of each conversion, except in hold
   assign upd_w = end_w && (mode_w != dsr_pkg::MODE_HOLD); // R7

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int k = 0; k < dsr_pkg::DIGITS; k++) begin
            shown_q[k] <= '0;
         end
      end else if (upd_w) begin
         for (int k = 0; k < dsr_pkg::DIGITS; k++) begin
            shown_q[k] <= fmt_w[k]; // R3
         end
      end
   end

   // Scan phases: even = gap with data set up, odd = one digit selected.
   // The gap costs display duty but keeps selects apart and data settled.
   assign scan_next_w = (scan_q == dsr_pkg::SCAN_LAST) ? '0 : scan_q + 1'b1;
   assign scan_dig_w = scan_next_w[2:1];
   assign scan_on_w = scan_next_w[0];

   always_comb begin
      readout_d = '0;
      case (scan_dig_w)
         2'h0: begin
            readout_d.bcd = shown_q[2]; // R4
            readout_d.sel.top_digit_select = scan_on_w; // R13
         end
         2'h1: begin
            readout_d.bcd = shown_q[1]; // R4
            readout_d.sel.middle_digit_select = scan_on_w; // R13
         end
         default: begin
            readout_d.bcd = shown_q[0]; // R4
            readout_d.sel.bottom_digit_select = scan_on_w; // R13
         end
      endcase
   end

   // Readout changes only on timebase ticks, so data stays put under a select
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         scan_q <= '0;
         readout_q <= '0;
      end else if (osc_tick) begin
         scan_q <= scan_next_w;
         readout_q <= readout_d; // R13
      end
   end

   // Conversion end marker
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         conv_done_q <= 1'b0;
      end else begin
         conv_done_q <= end_w;
      end
   end

   // Integrator switches follow the sequence state directly
   assign integ_connect = (state_q == dsr_pkg::ST_INTEG); // R1
   assign ref_connect = (state_q == dsr_pkg::ST_DEINT); // R1
   assign readout = readout_q;
   assign conv_done = conv_done_q;

endmodule

//--- dv/dsr_chk.sv
// Checker for the readout sequencer: slope timing, conversion end and scan.
// Assumes it is bound to the sequencer top and sees its ports only.
module dsr_chk #(
   parameter int OSC_CYCLES = 20,
   parameter int COUNT_CYCLES = 2,
   parameter int INT_COUNTS = 20
) (
   input wire logic clk, // System clock
   input wire logic sys_rst, // Async reset
   input wire logic restore_pin, // Comparator input
   input wire logic integ_connect, // Input slope
   input wire logic ref_connect, // Reference slope
   input wire dsr_pkg::readout_t readout, // Scan outputs
   input wire logic conv_done // End pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int GAP = 2 * OSC_CYCLES + 2;
   int icnt_q;
   int rcnt_q;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Slope run lengths; a stuck state shows up as an overlong count
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         icnt_q <= 0;
         rcnt_q <= 0;
      end else begin
         icnt_q <= integ_connect ? icnt_q + 1 : 0;
         rcnt_q <= ref_connect ? rcnt_q + 1 : 0;
      end
   end
   // Restore held long enough to pass the synchroniser
   sequence restore_seen;
      (ref_connect && restore_pin) ##1 restore_pin[*2];
   endsequence
   a_sel_one_hot: assert property ($onehot0(readout.sel))
      else $error("two digit selects");
   a_bcd_held: assert property ((|readout.sel) ##1 (readout.sel == $past(readout.sel))
      |-> $stable(readout.bcd)) else $error("digit data moved");
   a_slopes_apart: assert property (!(integ_connect && ref_connect))
      else $error("both slopes on");
   a_integ_length: assert property ($fell(integ_connect)
      |-> icnt_q == INT_COUNTS * COUNT_CYCLES) else $error("integrate length");
   a_ref_follows: assert property ($fell(integ_connect) |-> ref_connect)
      else $error("reference not switched in");
   a_ref_bounded: assert property (ref_connect |-> rcnt_q < 1000 * COUNT_CYCLES + 4)
      else $error("reference slope too long");
   a_restore_stops: assert property (restore_seen |-> ##[0:2] !ref_connect)
      else $error("restore ignored");
   a_done_after_ref: assert property ($fell(ref_connect) |-> ##[0:2] conv_done)
      else $error("no end pulse");
   a_done_pulse: assert property (conv_done |=> !conv_done)
      else $error("end pulse too long");
   a_scan_top_mid: assert property ($fell(readout.sel.top_digit_select)
      |-> ##[1:GAP] readout.sel.middle_digit_select) else $error("middle not next");
   a_scan_mid_bot: assert property ($fell(readout.sel.middle_digit_select)
      |-> ##[1:GAP] readout.sel.bottom_digit_select) else $error("bottom not next");
endmodule

bind dual_slope_bcd_readout_sequencer dsr_chk #(.OSC_CYCLES(OSC_CYCLES),
   .COUNT_CYCLES(COUNT_CYCLES), .INT_COUNTS(INT_COUNTS)) dsr_chk_inst (.clk(clk),
   .sys_rst(sys_rst), .restore_pin(restore_pin), .integ_connect(integ_connect),
   .ref_connect(ref_connect), .readout(readout), .conv_done(conv_done));

//--- dv/dsr_display_latch.sv
// Model of the per-digit display latches on the far side of the scan.
// Assumes active-high selects; each latch follows its digit while selected.
module dsr_display_latch (
   input wire logic clk, // System clock
   input wire dsr_pkg::readout_t readout, // Scan outputs
   output logic [11:0] shown // Top, middle, bottom codes
);
   timeunit 1ns;
   timeprecision 1ps;
   // Strobe is the inverted select: open while selected, held once it drops
   always_ff @(posedge clk) begin
      if (readout.sel.top_digit_select) shown[11:8] <= readout.bcd;
      if (readout.sel.middle_digit_select) shown[7:4] <= readout.bcd;
      if (readout.sel.bottom_digit_select) shown[3:0] <= readout.bcd;
   end
endmodule

//--- dv/dual_slope_bcd_readout_sequencer_bench.sv
// Bench for the readout sequencer: readings, codes, rates and hold.
// Assumes the package, checker and display latch model are compiled first.
module dual_slope_bcd_readout_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int OSC = 20;
   localparam int CNT = 2;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic rate_high_pin = 1'b0;
   logic rate_mid_pin = 1'b0;
   logic restore_pin = 1'b0;
   logic sign_pin = 1'b0;
   logic integ_connect;
   logic ref_connect;
   logic conv_done;
   logic integ_q = 1'b0;
   dsr_pkg::readout_t readout;
   logic [11:0] shown;
   logic [11:0] held;
   int err_count = 0;
   int checks = 0;
   int cyc = 0;
   int last = 0;
   int gap = 0;
   int n;
   logic neg;
   int cn[5] = '{96, 103, 996, 1003, 1003};
   logic cs[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

   always #20 clk = ~clk;

   dual_slope_bcd_readout_sequencer #(.OSC_CYCLES(OSC), .COUNT_CYCLES(CNT), .INT_COUNTS(20))
      dual_slope_bcd_readout_sequencer_inst (.clk(clk), .sys_rst(sys_rst),
      .rate_high_pin(rate_high_pin), .rate_mid_pin(rate_mid_pin), .restore_pin(restore_pin),
      .sign_pin(sign_pin), .integ_connect(integ_connect), .ref_connect(ref_connect),
      .readout(readout), .conv_done(conv_done));
   dsr_display_latch dsr_display_latch_inst (.clk(clk), .readout(readout), .shown(shown));

   // Start-to-start spacing in clocks, taken at each rise of the input slope
   always @(posedge clk) begin
      cyc <= cyc + 1;
      integ_q <= integ_connect;
      if (integ_connect && !integ_q) begin
         gap <= cyc - last;
         last <= cyc;
      end
   end

   // Expected digit codes for a count and polarity
   function automatic logic [11:0] enc(int v, logic ng);
      if (v >= 1000) return ng ? 12'haaa : 12'hbbb;
      if (ng && v >= 100) return 12'haaa;
      if (ng) return {4'ha, 4'(v / 10), 4'(v % 10)};
      return {4'(v / 100), 4'((v / 10) % 10), 4'(v % 10)};
   endfunction

   task automatic check(logic [11:0] seen, logic [11:0] exp, string what);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
      end
      $display("done: %s", what);
   endtask

   // One conversion; restore after about n count ticks, never when n is 0
   task automatic conv(int cnt, logic ng);
      int w;
      for (w = 0; w < 5000 && !integ_connect; w++) @(negedge clk);
      sign_pin = ng;
      for (w = 0; w < 200 && !ref_connect; w++) @(negedge clk);
      if (cnt > 0) begin
         repeat (CNT * cnt) @(negedge clk);
         restore_pin = 1'b1;
      end
      for (w = 0; w < 3000 && !conv_done; w++) @(negedge clk);
      restore_pin = 1'b0;
      if (w >= 3000) begin
         err_count++;
         $display("[FAIL] %0t conversion did not end", $time);
      end
   endtask

   // Synchroniser and tick phase blur the count, so accept a small window
   task automatic show(int cnt, logic ng, string what);
      logic hit;
      hit = 1'b0;
      repeat (14 * OSC) @(negedge clk);
      for (int k = cnt - 3; k <= cnt + 3; k++) hit |= (shown === enc(k, ng));
      check({11'h0, hit}, 12'h1, what);
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      void'($urandom(32'hda32));
      repeat (5) @(negedge clk);
      sys_rst = 1'b0;
      // Random readings in slow mode, both polarities
      repeat (6) begin
         neg = 1'($urandom_range(1, 0));
         n = neg ? $urandom_range(96, 3) : $urandom_range(996, 3);
         conv(n, neg);
         show(n, neg, "random reading");
      end
      check(12'(gap), 12'(int'(dsr_pkg::SLOW_TICKS) * OSC), "slow period");
      // Code boundaries and both overranges
      foreach (cn[i]) begin
         conv(cn[i] >= 1000 ? 0 : cn[i], cs[i]);
         show(cn[i], cs[i], "corner code");
      end
      rate_high_pin = 1'b1;
      repeat (3) conv(10, 1'b0);
      check(12'(gap), 12'(int'(dsr_pkg::FAST_TICKS) * OSC), "fast period");
      // Hold wins over the fast request and freezes the digits
      // The latches lag the last fast result by up to a scan, so copy after they settle
      rate_mid_pin = 1'b1;
      repeat (14 * OSC) @(negedge clk);
      held = shown;
      n = $urandom_range(500, 200);
      repeat (2) conv(n, 1'b0);
      repeat (14 * OSC) @(negedge clk);
      check(shown, held, "hold freeze");
      check(12'(gap), 12'(int'(dsr_pkg::SLOW_TICKS) * OSC), "hold period");
      rate_mid_pin = 1'b0;
      conv(n, 1'b0);
      show(n, 1'b0, "after hold");
      conv(n, 1'b0);
      check(12'(gap), 12'(int'(dsr_pkg::SLOW_TICKS) * OSC), "rate after hold");
      final_report();
   end

   // About 16 slow periods of work; the limit leaves nearly half again of margin
   initial begin
      repeat (90000) @(posedge clk);
      err_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      final_report();
   end
endmodule
